// ---- serial_pkg.sv ----
package serial_pkg;

    // Core clocks per async bit and half bit
    localparam int BIT_CYCLES = 16;
    localparam int HALF_CYCLES = BIT_CYCLES / 2;

    // Character shape
    localparam logic [3:0] DATA_BITS = 4'h8;
    localparam logic [3:0] FRAME_BITS = 4'ha;
    localparam logic [3:0] BREAK_BITS = 4'he;
    localparam logic [3:0] LAST_RX_BIT = 4'h9;
    localparam logic [13:0] BREAK_FRAME = 14'h2000;

    // Register offsets
    localparam logic [2:0] TX_CTRL_ADDR = 3'h0;
    localparam logic [2:0] RX_CTRL_ADDR = 3'h1;
    localparam logic [2:0] RATE_ADDR = 3'h2;
    localparam logic [2:0] HOLD_ADDR = 3'h3;
    localparam logic [2:0] RX_DATA_ADDR = 3'h4;

    // Field positions
    localparam int TXC_ENABLE_POS = 0;
    localparam int TXC_BREAK_POS = 1;
    localparam int TXC_SYNC_POS = 2;
    localparam int TXC_MASTER_POS = 3;
    localparam int TXC_SHIFT_EMPTY_POS = 4;
    localparam int TXC_TX_FLAG_POS = 5;
    localparam int RXC_PORT_EN_POS = 0;
    localparam int RXC_SINGLE_POS = 1;
    localparam int RXC_CONT_POS = 2;
    localparam int RXC_FRAMING_ERROR_FLAG_POS = 3;
    localparam int RXC_RX_FLAG_POS = 4;
    localparam int RATE_WAKE_POS = 0;
    localparam int RATE_POL_POS = 1;
    localparam int RATE_IDLE_POS = 2;

    typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} tx_state_t;
    typedef enum logic {RX_IDLE, RX_BUSY} rx_state_t;

    typedef struct packed {
        logic transmit_enable;
        logic send_break_request;
        logic sync_mode;
        logic clock_source_master;
        logic serial_port_enable;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic wake_on_break_arm;
        logic clock_polarity_select;
        logic [7:0] hold_data;
        logic hold_full;
        logic hold_brk;
        tx_state_t tx_state;
        logic [13:0] tx_shift;
        logic [3:0] tx_left;
        logic tx_phase;
        logic tx_brk;
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        rx_state_t rx_state;
        logic [3:0] rx_bits;
        logic [7:0] rx_cnt;
        logic [7:0] rx_shift;
        logic [7:0] rx_data;
        logic receive_interrupt_flag;
        logic framing_error_flag;
        logic [7:0] rd_data;
        logic data_o;
        logic data_oe;
        logic clk_o;
        logic clk_oe;
    } dev_state_t;

    localparam dev_state_t DEV_RESET = '{tx_state: TX_IDLE,
        rx_state: RX_IDLE, rx_s1: 1'b1, rx_s2: 1'b1, rx_prev: 1'b1,
        data_o: 1'b1, clk_o: 1'b1, default: '0};

endpackage : serial_pkg

// ---- serial_link_if.sv ----
`timescale 1ns/10ps
interface serial_link_if;
    // Device drives
    logic receive_data_pin_dev_o;
    logic receive_data_pin_dev_oe;
    logic transmit_clock_pin_dev_o;
    logic transmit_clock_pin_dev_oe;
    // Far end drives
    logic receive_data_pin_far_o;
    logic receive_data_pin_far_oe;
    // Resolved levels, pulled high
    logic receive_data_pin_line;
    logic transmit_clock_pin_line;

    assign receive_data_pin_line = receive_data_pin_dev_oe ?
        receive_data_pin_dev_o :
        (receive_data_pin_far_oe ? receive_data_pin_far_o : 1'b1);
    assign transmit_clock_pin_line = transmit_clock_pin_dev_oe ?
        transmit_clock_pin_dev_o : 1'b1;

    modport device (
        output receive_data_pin_dev_o, receive_data_pin_dev_oe,
        output transmit_clock_pin_dev_o, transmit_clock_pin_dev_oe,
        input receive_data_pin_line, transmit_clock_pin_line
    );
    modport far (
        output receive_data_pin_far_o, receive_data_pin_far_oe,
        input receive_data_pin_line, transmit_clock_pin_line
    );
endinterface : serial_link_if

// ---- baud_tick.sv ----
`timescale 1ns/10ps
module baud_tick #(
    parameter int DIV = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Control and pulse
    input wire logic run,
    output logic tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } tick_state_t;

    tick_state_t s_reg;
    tick_state_t s_next;

    assign tick = s_reg.tick;

    // Count while running, pulse every DIV cycles
    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (!run) begin
            s_next.cnt = '0;
        end else if (s_reg.cnt == 8'(DIV - 1)) begin
            s_next.cnt = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + 8'h01;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule : baud_tick

// ---- serial_transceiver.sv ----
// Summary of operation
// - Wake while armed sets receive flag
// - Rising data line clears wake arm
// - Reading receive data clears flag
// - Check receiver idle before arming
// - Receiver idle while wake armed
// - Break is start, twelve zeros, stop
// - Holding write with break+enable starts break
// - Break sends zeros up to its stop bit
// - Break request clears after stop bit
// - Shift-empty tracks break too
// - LIN header: break, dummy, then sync
// - Transmit flag means holding empty
// - Received break: flag, framing error, zero
// - Wake sees two edges, then next byte
// - Sync mode: no start, no stop
// - Sync master; receive enables pick direction
// - Master drives clock pin
// - One clock per data bit only
// - Data changes on leading clock edge
// - Polarity sets idle level and edge
// - Sync transmit drives data pin
// - Holding waits while shifter busy
// - Half-duplex data line
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module serial_transceiver
    import serial_pkg::*;
#(
    parameter int BIT_LEN = BIT_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Serial link
    serial_link_if.device link
);
    localparam int HALF_LEN = BIT_LEN / 2;

    dev_state_t s_reg;
    dev_state_t s_next;
    logic tick;
    logic tx_run;
    logic fell;
    logic rose;
    logic sync_tx;
    logic async_on;
    logic brk_busy;
    logic [7:0] rd_value;

    // Half-bit tick for transmit
    assign tx_run = (s_reg.tx_state != TX_IDLE);
    baud_tick #(.DIV(HALF_LEN)) u_tick (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(tx_run),
        .tick(tick)
    );

    // Decoded conditions
    assign fell = s_reg.rx_prev & ~s_reg.rx_s2;
    assign rose = ~s_reg.rx_prev & s_reg.rx_s2;
    assign sync_tx = s_reg.sync_mode & s_reg.clock_source_master
        & s_reg.serial_port_enable & ~s_reg.single_receive_enable
        & ~s_reg.continuous_receive_enable;
    assign async_on = s_reg.serial_port_enable & ~s_reg.sync_mode;
    assign brk_busy = s_reg.tx_brk | (s_reg.hold_full & s_reg.hold_brk);

    // Register read mux
    always_comb begin
        rd_value = '0;
        case (reg_addr)
            TX_CTRL_ADDR: begin
                rd_value[TXC_ENABLE_POS] = s_reg.transmit_enable;
                rd_value[TXC_BREAK_POS] = s_reg.send_break_request;
                rd_value[TXC_SYNC_POS] = s_reg.sync_mode;
                rd_value[TXC_MASTER_POS] = s_reg.clock_source_master;
                rd_value[TXC_SHIFT_EMPTY_POS] = ~tx_run;
                rd_value[TXC_TX_FLAG_POS] = ~s_reg.hold_full;
            end
            RX_CTRL_ADDR: begin
                rd_value[RXC_PORT_EN_POS] = s_reg.serial_port_enable;
                rd_value[RXC_SINGLE_POS] = s_reg.single_receive_enable;
                rd_value[RXC_CONT_POS] = s_reg.continuous_receive_enable;
                rd_value[RXC_FRAMING_ERROR_FLAG_POS] = s_reg.framing_error_flag;
                rd_value[RXC_RX_FLAG_POS] = s_reg.receive_interrupt_flag;
            end
            RATE_ADDR: begin
                rd_value[RATE_WAKE_POS] = s_reg.wake_on_break_arm;
                rd_value[RATE_POL_POS] = s_reg.clock_polarity_select;
                rd_value[RATE_IDLE_POS] = (s_reg.rx_state == RX_IDLE);
            end
            RX_DATA_ADDR: rd_value = s_reg.rx_data;
            default: rd_value = '0;
        endcase
    end

    // Next state
    always_comb begin
        s_next = s_reg;
        s_next.rd_data = '0;
        s_next.rx_s1 = link.receive_data_pin_line;
        s_next.rx_s2 = s_reg.rx_s1;
        s_next.rx_prev = s_reg.rx_s2;

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                TX_CTRL_ADDR: begin
                    s_next.transmit_enable = reg_wdata[TXC_ENABLE_POS];
                    s_next.send_break_request = reg_wdata[TXC_BREAK_POS];
                    s_next.sync_mode = reg_wdata[TXC_SYNC_POS];
                    s_next.clock_source_master =
                        reg_wdata[TXC_MASTER_POS];
                end
                RX_CTRL_ADDR: begin
                    s_next.serial_port_enable = reg_wdata[RXC_PORT_EN_POS];
                    s_next.single_receive_enable =
                        reg_wdata[RXC_SINGLE_POS];
                    s_next.continuous_receive_enable =
                        reg_wdata[RXC_CONT_POS];
                end
                RATE_ADDR: begin
                    s_next.wake_on_break_arm = reg_wdata[RATE_WAKE_POS];
                    s_next.clock_polarity_select = reg_wdata[RATE_POL_POS];
                end
                default: begin
                end
            endcase
        end

        // Reads answer next cycle
        if (reg_rd) begin
            s_next.rd_data = rd_value;
            if (reg_addr == RX_DATA_ADDR) begin
                s_next.receive_interrupt_flag = 1'b0;
            end
        end

        // Transmit engine
        case (s_reg.tx_state)
            TX_IDLE: begin
                if (s_reg.hold_full && s_reg.transmit_enable) begin
                    s_next.tx_phase = 1'b0;
                    if (sync_tx) begin
                        // Data and leading edge together, LSB first
                        s_next.hold_full = 1'b0;
                        s_next.tx_shift = {6'h00, s_reg.hold_data};
                        s_next.tx_left = DATA_BITS;
                        s_next.data_o = s_reg.hold_data[0];
                        s_next.clk_o = ~s_reg.clock_polarity_select;
                        s_next.tx_state = TX_SYNC;
                    end else if (async_on) begin
                        s_next.hold_full = 1'b0;
                        s_next.tx_state = TX_ASYNC;
                        if (s_reg.hold_brk) begin
                            s_next.tx_shift = BREAK_FRAME;
                            s_next.tx_left = BREAK_BITS;
                            s_next.tx_brk = 1'b1;
                            s_next.clk_o = 1'b0;
                        end else begin
                            s_next.tx_shift =
                                {4'hf, 1'b1, s_reg.hold_data, 1'b0};
                            s_next.tx_left = FRAME_BITS;
                            s_next.clk_o = 1'b0;
                        end
                    end
                end
            end
            TX_ASYNC: begin
                if (tick) begin
                    s_next.tx_phase = ~s_reg.tx_phase;
                    if (s_reg.tx_phase) begin
                        s_next.tx_shift = s_reg.tx_shift >> 1;
                        s_next.tx_left = s_reg.tx_left - 4'h1;
                        s_next.clk_o = s_reg.tx_shift[1];
                        if (s_reg.tx_left == 4'h1) begin
                            s_next.tx_state = TX_IDLE;
                            s_next.clk_o = 1'b1;
                            if (s_reg.tx_brk) begin
                                s_next.tx_brk = 1'b0;
                                s_next.send_break_request = 1'b0;
                            end
                        end
                    end
                end
            end
            TX_SYNC: begin
                if (tick) begin
                    if (!s_reg.tx_phase) begin
                        // Trailing edge; data held
                        s_next.clk_o = s_reg.clock_polarity_select;
                        s_next.tx_phase = 1'b1;
                    end else if (s_reg.tx_left == 4'h1) begin
                        s_next.tx_state = TX_IDLE;
                    end else begin
                        // Leading edge with the next bit
                        s_next.tx_shift = s_reg.tx_shift >> 1;
                        s_next.tx_left = s_reg.tx_left - 4'h1;
                        s_next.data_o = s_reg.tx_shift[1];
                        s_next.clk_o = ~s_reg.clock_polarity_select;
                        s_next.tx_phase = 1'b0;
                    end
                end
            end
            default: s_next.tx_state = TX_IDLE;
        endcase

        // Holding write, after any load
        if (reg_wr && reg_addr == HOLD_ADDR && s_reg.transmit_enable) begin
            s_next.hold_data = reg_wdata;
            s_next.hold_full = 1'b1;
            s_next.hold_brk = s_reg.send_break_request & async_on
                & ~brk_busy;
        end

        // Receiver: wake watch or async character
        if (s_reg.wake_on_break_arm) begin
            s_next.rx_state = RX_IDLE;
            if (fell) begin
                s_next.receive_interrupt_flag = 1'b1;
                s_next.rx_data = '0;
            end
            if (rose) begin
                s_next.wake_on_break_arm = 1'b0;
            end
        end else if (async_on) begin
            case (s_reg.rx_state)
                RX_IDLE: begin
                    if (fell) begin
                        s_next.rx_cnt = 8'(HALF_LEN - 1);
                        s_next.rx_bits = '0;
                        s_next.rx_state = RX_BUSY;
                    end
                end
                RX_BUSY: begin
                    if (s_reg.rx_cnt != 8'h00) begin
                        s_next.rx_cnt = s_reg.rx_cnt - 8'h01;
                    end else begin
                        s_next.rx_cnt = 8'(BIT_LEN - 1);
                        s_next.rx_bits = s_reg.rx_bits + 4'h1;
                        if (s_reg.rx_bits == 4'h0 && s_reg.rx_s2) begin
                            s_next.rx_state = RX_IDLE;
                        end else if (s_reg.rx_bits == LAST_RX_BIT) begin
                            s_next.rx_data = s_reg.rx_shift;
                            s_next.framing_error_flag = ~s_reg.rx_s2;
                            s_next.receive_interrupt_flag = 1'b1;
                            s_next.rx_state = RX_IDLE;
                        end else if (s_reg.rx_bits != 4'h0) begin
                            s_next.rx_shift =
                                {s_reg.rx_s2, s_reg.rx_shift[7:1]};
                        end
                    end
                end
                default: s_next.rx_state = RX_IDLE;
            endcase
        end else begin
            s_next.rx_state = RX_IDLE;
        end

        // Pin drivers and idle levels
        if (s_next.tx_state == TX_IDLE) begin
            s_next.clk_o = s_next.sync_mode ?
                s_next.clock_polarity_select : 1'b1;
        end
        s_next.clk_oe = s_next.serial_port_enable & (s_next.sync_mode ?
            s_next.clock_source_master : s_next.transmit_enable);
        s_next.data_oe = s_next.sync_mode & s_next.clock_source_master
            & s_next.serial_port_enable & ~s_next.single_receive_enable
            & ~s_next.continuous_receive_enable;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= DEV_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs from the state register
    assign reg_rdata = s_reg.rd_data;
    assign link.receive_data_pin_dev_o = s_reg.data_o;
    assign link.receive_data_pin_dev_oe = s_reg.data_oe;
    assign link.transmit_clock_pin_dev_o = s_reg.clk_o;
    assign link.transmit_clock_pin_dev_oe = s_reg.clk_oe;
endmodule : serial_transceiver

// ---- link_partner.sv ----
`timescale 1ns/10ps
module link_partner
    import serial_pkg::*;
#(
    parameter int BIT_LEN = BIT_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // User side
    input wire logic sync_sel,
    input wire logic clk_pol,
    input wire logic send_break,
    output logic [7:0] byte_out,
    output logic byte_valid,
    output logic break_seen,
    output logic break_busy,
    // Serial link
    serial_link_if.far link
);
    typedef struct packed {
        logic d1, d2, dprev;
        logic c1, c2, cprev;
        rx_state_t rx_state;
        logic [3:0] bits;
        logic [7:0] cnt;
        logic [7:0] shift;
        logic [7:0] byte_out;
        logic byte_valid;
        logic break_seen;
        logic [3:0] brk_bits;
        logic [7:0] brk_cnt;
        logic brk_on;
    } far_state_t;

    localparam far_state_t FAR_RESET = '{d1: 1'b1, d2: 1'b1, dprev: 1'b1,
        c1: 1'b1, c2: 1'b1, cprev: 1'b1, rx_state: RX_IDLE, default: '0};

    far_state_t s_reg;
    far_state_t s_next;
    logic trailing;

    // Trailing edge: clock back to idle
    assign trailing = clk_pol ? (~s_reg.cprev & s_reg.c2)
                              : (s_reg.cprev & ~s_reg.c2);

    always_comb begin
        s_next = s_reg;
        s_next.d1 = link.receive_data_pin_line;
        s_next.d2 = s_reg.d1;
        s_next.dprev = s_reg.d2;
        s_next.c1 = link.transmit_clock_pin_line;
        s_next.c2 = s_reg.c1;
        s_next.cprev = s_reg.c2;
        s_next.byte_valid = 1'b0;

        if (sync_sel) begin
            // Slave: sample on trailing edge
            s_next.rx_state = RX_IDLE;
            if (trailing) begin
                s_next.shift = {s_reg.d2, s_reg.shift[7:1]};
                s_next.bits = s_reg.bits + 4'h1;
                if (s_reg.bits == DATA_BITS - 4'h1) begin
                    s_next.bits = '0;
                    s_next.byte_out = {s_reg.d2, s_reg.shift[7:1]};
                    s_next.byte_valid = 1'b1;
                end
            end
        end else begin
            // Async receive on clock line
            case (s_reg.rx_state)
                RX_IDLE: begin
                    s_next.bits = '0;
                    if (s_reg.cprev && !s_reg.c2) begin
                        s_next.cnt = 8'(BIT_LEN / 2 - 1);
                        s_next.rx_state = RX_BUSY;
                    end
                end
                RX_BUSY: begin
                    if (s_reg.cnt != 8'h00) begin
                        s_next.cnt = s_reg.cnt - 8'h01;
                    end else begin
                        s_next.cnt = 8'(BIT_LEN - 1);
                        s_next.bits = s_reg.bits + 4'h1;
                        if (s_reg.bits == LAST_RX_BIT) begin
                            s_next.byte_out = s_reg.shift;
                            s_next.byte_valid = s_reg.c2;
                            s_next.break_seen = ~s_reg.c2
                                & (s_reg.shift == 8'h00);
                            s_next.rx_state = RX_IDLE;
                        end else if (s_reg.bits != 4'h0) begin
                            s_next.shift = {s_reg.c2, s_reg.shift[7:1]};
                        end
                    end
                end
                default: s_next.rx_state = RX_IDLE;
            endcase
        end

        // Break toward the device
        if (s_reg.brk_on) begin
            if (s_reg.brk_cnt != 8'h00) begin
                s_next.brk_cnt = s_reg.brk_cnt - 8'h01;
            end else begin
                s_next.brk_cnt = 8'(BIT_LEN - 1);
                s_next.brk_bits = s_reg.brk_bits - 4'h1;
                if (s_reg.brk_bits == 4'h1) begin
                    s_next.brk_on = 1'b0;
                end
            end
        end else if (send_break && !sync_sel) begin
            s_next.brk_on = 1'b1;
            s_next.brk_bits = BREAK_BITS - 4'h1;
            s_next.brk_cnt = 8'(BIT_LEN - 1);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= FAR_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs from the state register; far data level tied low
    assign byte_out = s_reg.byte_out;
    assign byte_valid = s_reg.byte_valid;
    assign break_seen = s_reg.break_seen;
    assign break_busy = s_reg.brk_on;
    assign link.receive_data_pin_far_o = 1'b0;
    assign link.receive_data_pin_far_oe = s_reg.brk_on;
endmodule : link_partner

// ---- serial_link_assertions.sv ----
`timescale 1ns/10ps
module serial_link_assertions #(
    parameter int BIT_LEN = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Link drives
    input wire logic receive_data_pin_dev_o,
    input wire logic receive_data_pin_dev_oe,
    input wire logic transmit_clock_pin_dev_o,
    input wire logic transmit_clock_pin_dev_oe,
    input wire logic receive_data_pin_far_o,
    input wire logic receive_data_pin_far_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] low_reg;
    logic d_o, d_oe, c_o, atx;
    // Short names; async TX uses clock pin
    assign d_o = receive_data_pin_dev_o;
    assign d_oe = receive_data_pin_dev_oe;
    assign c_o = transmit_clock_pin_dev_o;
    assign atx = transmit_clock_pin_dev_oe && !d_oe;
    // Low stretch length on async pin
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_reg <= 8'h00;
        end else begin
            low_reg <= (atx && !c_o) ? low_reg + 8'h01 : 8'h00;
        end
    end
    sequence rise_s;
        atx && $rose(c_o);
    endsequence
    sequence high_s;
        c_o [*7];
    endsequence
    stop_bit_a: assert property (rise_s |=> high_s)
        else $error("high bit short");
    break_len_a: assert property (low_reg <= 8'(13 * BIT_LEN + 3))
        else $error("low too long");
    half_duplex_a: assert property (!(d_oe && receive_data_pin_far_oe))
        else $error("both drive data");
    clock_with_data_a: assert property (d_oe |-> transmit_clock_pin_dev_oe)
        else $error("data without clock");
    lead_edge_a: assert property (
        d_oe && $past(d_oe) && $changed(d_o) |-> $changed(c_o))
        else $error("data off leading edge");
    data_hold_a: assert property (d_oe && $changed(c_o) |=> $stable(d_o) [*3])
        else $error("data not held");
    half_period_a: assert property (d_oe && $changed(c_o) |=> !$changed(c_o) [*3])
        else $error("half period short");
    far_low_a: assert property (receive_data_pin_far_oe |-> !receive_data_pin_far_o)
        else $error("far drives high");
endmodule : serial_link_assertions

// ---- test_serial_break_wake_sync_master.sv ----
`timescale 1ns/10ps
module test_serial_break_wake_sync_master import serial_pkg::*;;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic sync_sel = 1'b0;
    logic clk_pol = 1'b0;
    logic send_break = 1'b0;
    logic [7:0] reg_rdata, byte_out, d, b;
    logic byte_valid, break_seen, break_busy, brk;
    int mismatches = 0;
    int total_checks = 0;
    int edges = 0;
    serial_link_if link ();
    serial_transceiver #(.BIT_LEN(8)) u_serial_transceiver (.core_clk(core_clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .link(link),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    link_partner #(.BIT_LEN(8)) u_link_partner (.core_clk(core_clk), .link(link),
        .rst_n(rst_n), .sync_sel(sync_sel), .clk_pol(clk_pol), .byte_out(byte_out),
        .send_break(send_break), .byte_valid(byte_valid), .break_seen(break_seen),
        .break_busy(break_busy));
    serial_link_assertions #(.BIT_LEN(8)) u_serial_link_assertions (
        .core_clk(core_clk), .rst_n(rst_n),
        .receive_data_pin_dev_o(link.receive_data_pin_dev_o),
        .receive_data_pin_dev_oe(link.receive_data_pin_dev_oe),
        .transmit_clock_pin_dev_o(link.transmit_clock_pin_dev_o),
        .transmit_clock_pin_dev_oe(link.transmit_clock_pin_dev_oe),
        .receive_data_pin_far_o(link.receive_data_pin_far_o),
        .receive_data_pin_far_oe(link.receive_data_pin_far_oe));
    // Clock and clock-line edge count
    always #50 core_clk = ~core_clk;
    always @(link.transmit_clock_pin_line) edges++;
    task check(input string name, input logic [7:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rdr(input logic [2:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask : rdr
    task far_break(input int wait_cycles);
        @(posedge core_clk);
        send_break <= 1'b1;
        @(posedge core_clk);
        send_break <= 1'b0;
        repeat (wait_cycles) @(posedge core_clk);
    endtask : far_break
    // Wait for a far-end byte, noting breaks
    task wait_byte;
        int n;
        n = 0;
        b = 'x;
        brk = 1'b0;
        @(negedge core_clk);
        while (byte_valid !== 1'b1 && n < 600) begin
            @(negedge core_clk);
            brk = brk | break_seen;
            n++;
        end
        if (byte_valid === 1'b1) b = byte_out;
    endtask : wait_byte
    task test_break;
        wr(RX_CTRL_ADDR, 8'h01);
        wr(TX_CTRL_ADDR, 8'h03);
        wr(HOLD_ADDR, 8'ha5);
        wr(HOLD_ADDR, 8'h55);
        rdr(TX_CTRL_ADDR);
        check("tx in break", d, 8'h03);
        wait_byte();
        check("break seen", {7'h00, brk}, 8'h01);
        check("after break", b, 8'h55);
        repeat (20) @(posedge core_clk);
        rdr(TX_CTRL_ADDR);
        check("tx after", d, 8'h31);
        wr(TX_CTRL_ADDR, 8'h00);
        $display("test_break done");
    endtask : test_break
    task test_wake;
        rdr(RATE_ADDR);
        check("idle", d, 8'h04);
        wr(RATE_ADDR, 8'h01);
        far_break(200);
        rdr(RATE_ADDR);
        check("arm", d, 8'h04);
        rdr(RX_CTRL_ADDR);
        check("wake flag", d, 8'h11);
        rdr(RX_DATA_ADDR);
        rdr(RX_CTRL_ADDR);
        check("flag clr", d, 8'h01);
        $display("test_wake done");
    endtask : test_wake
    task test_rx_break;
        far_break(200);
        rdr(RX_CTRL_ADDR);
        check("break status", d, 8'h19);
        rdr(RX_DATA_ADDR);
        check("break data", d, 8'h00);
        $display("test_rx_break done");
    endtask : test_rx_break
    task test_sync(input logic pol);
        wr(RATE_ADDR, {6'h00, pol, 1'b0});
        wr(TX_CTRL_ADDR, 8'h0d);
        repeat (4) @(posedge core_clk);
        sync_sel <= 1'b1;
        clk_pol <= pol;
        edges = 0;
        wr(HOLD_ADDR, 8'h3c);
        wr(HOLD_ADDR, 8'hc3);
        wait_byte();
        check("sync 1", b, 8'h3c);
        wait_byte();
        check("sync 2", b, 8'hc3);
        repeat (20) @(posedge core_clk);
        check("edges", 8'(edges), 8'h20);
        check("clock idle", {7'h00, link.transmit_clock_pin_line}, {7'h00, pol});
        wr(TX_CTRL_ADDR, 8'h00);
        $display("test_sync done");
    endtask : test_sync
    task finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    // Main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        test_break();
        test_wake();
        test_rx_break();
        test_sync(1'b0);
        test_sync(1'b1);
        finish_test();
    end
    // Watchdog
    initial begin
        #2000000;
        mismatches++;
        finish_test();
    end
endmodule : test_serial_break_wake_sync_master
